// ### rtl/sdfp_pkg.sv
// package with constants for the switch drive fault protection block
package sdfp_pkg;
   // sense levels in millivolts
   localparam logic [11:0] SDFP_OCP_MV = 12'd1150;
   localparam int SDFP_MV_W = 12;
   // base drive current limits in milliamps
   localparam logic [4:0] SDFP_IB_MIN_MA = 5'd10;
   localparam logic [4:0] SDFP_IB_MAX_MA = 5'd31;
   // cable compensation, millivolts at nominal output millivolts
   localparam logic [15:0] SDFP_CABLE_MV = 16'd300;
   localparam logic [15:0] SDFP_VNOM_MV = 16'd5000;
   localparam int SDFP_OCP_LIMIT = 4;
   localparam int SDFP_SOFT_CYC = 8;
   typedef enum logic [3:0] {
      SDFP_OFF = 4'b0001,
      SDFP_SOFT = 4'b0010,
      SDFP_RUN = 4'b0100,
      SDFP_FAULT = 4'b1000
   } sdfp_state_t;
endpackage

// ### rtl/sdfp_base_drive.sv
// base drive current selection from peak sense level
`timescale 1ns/1ns
module sdfp_base_drive
   import sdfp_pkg::*;
#(
   parameter int STEPS = 8,
   parameter logic [4:0] TABLE [STEPS] = '{5'd10, 5'd13, 5'd16, 5'd19, 5'd22, 5'd25, 5'd28, 5'd31}
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic cycle_start,
   input wire logic [SDFP_MV_W-1:0] peak_sense_level,
   output logic [4:0] base_drive_ma
);
   logic [4:0] next_pick;
   logic [4:0] raw;
   int idx;
   // index spans 0..OVERCURRENT_EVENT level across steps; monotonic if the table is
   always_comb begin
      idx = (int'(peak_sense_level) * STEPS) / (int'(SDFP_OCP_MV) + 1);
      if (idx > STEPS - 1) begin
         idx = STEPS - 1;
      end
      raw = TABLE[idx];
      // clamp to documented range
      if (raw < SDFP_IB_MIN_MA) begin
         next_pick = SDFP_IB_MIN_MA;
      end else if (raw > SDFP_IB_MAX_MA) begin
         next_pick = SDFP_IB_MAX_MA;
      end else begin
         next_pick = raw;
      end
   end
   // update once a cycle so drive does not change mid-pulse
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         base_drive_ma <= SDFP_IB_MIN_MA;
      end else if (cycle_start) begin
         base_drive_ma <= next_pick;
      end
   end
   property p_drive_range;
      @(posedge core_clk) disable iff (!rst_b)
         base_drive_ma >= SDFP_IB_MIN_MA && base_drive_ma <= SDFP_IB_MAX_MA;
   endproperty
   a_drive_range: assert property (p_drive_range) else $error("base drive out of range");
   property p_drive_mono;
      @(posedge core_clk) disable iff (!rst_b)
         cycle_start && peak_sense_level == '1 ##1 1 |-> base_drive_ma == SDFP_IB_MAX_MA;
   endproperty
   a_drive_mono: assert property (p_drive_mono) else $error("top level not max drive");
endmodule

// ### rtl/sdfp_cable_comp.sv
// cable drop compensation offset on the feedback value
`timescale 1ns/1ns
module sdfp_cable_comp
   import sdfp_pkg::*;
#(
   parameter logic [15:0] VOUT_MV = 16'd5000,
   parameter logic [11:0] FULL_LOAD = 12'hFFF
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [11:0] load_estimate,
   input wire logic [15:0] feedback_in,
   output logic [15:0] feedback_comp
);
   logic [31:0] full_off;
   logic [43:0] prod;
   logic [15:0] next_off;
   // full-load offset scaled from the 5V reference
   assign full_off = (32'(SDFP_CABLE_MV) * 32'(VOUT_MV)) / 32'(SDFP_VNOM_MV);
   always_comb begin
      prod = 44'(full_off) * 44'(load_estimate > FULL_LOAD ? FULL_LOAD : load_estimate);
      next_off = 16'(prod / 44'(FULL_LOAD));
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         feedback_comp <= 16'h0000;
      end else begin
         feedback_comp <= feedback_in + next_off;
      end
   end
   property p_full_load;
      @(posedge core_clk) disable iff (!rst_b)
         load_estimate >= FULL_LOAD |=> feedback_comp == $past(feedback_in) + 16'(full_off);
   endproperty
   a_full_load: assert property (p_full_load) else $error("full load offset wrong");
   property p_no_load;
      @(posedge core_clk) disable iff (!rst_b) load_estimate == 12'h000 |=> feedback_comp == $past(feedback_in);
   endproperty
   a_no_load: assert property (p_no_load) else $error("no load offset nonzero");
endmodule

// ### rtl/sdfp_top.sv
// switching pulse gating with over-current and sense-short protection
`timescale 1ns/1ns
module sdfp_top
   import sdfp_pkg::*;
#(
   parameter int OCP_LIMIT = SDFP_OCP_LIMIT,
   parameter int SOFT_CYCLES = SDFP_SOFT_CYC,
   parameter logic [15:0] VOUT_MV = 16'd5000
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic uvlo,
   input wire logic cycle_start,
   input wire logic pulse_req,
   input wire logic [SDFP_MV_W-1:0] current_sense_input,
   input wire logic sense_short,
   input wire logic [11:0] load_estimate,
   input wire logic [15:0] feedback_in,
   output logic drive_on,
   output logic overcurrent_event,
   output logic shutdown,
   output logic running,
   output logic [SDFP_MV_W-1:0] peak_sense_level,
   output logic [4:0] base_drive_ma,
   output logic [15:0] feedback_comp
);
   sdfp_state_t state;
   logic oc_hit;
   logic gate_req;
   logic cut;
   logic [7:0] oc_count;
   logic [7:0] soft_count;
   logic oc_seen;
   // comparator on sampled sense voltage
   assign oc_hit = current_sense_input > SDFP_OCP_MV;
   // state machine; undervoltage lockout acts as logic reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= SDFP_OFF;
      end else if (uvlo) begin
         state <= SDFP_OFF;
      end else begin
         unique case (state)
            SDFP_OFF: begin
               state <= SDFP_SOFT;
            end
            SDFP_SOFT: begin
               // a short still present blocks full start-up
               if (soft_count >= 8'(SOFT_CYCLES) && !sense_short) begin
                  state <= SDFP_RUN;
               end
            end
            SDFP_RUN: begin
               if (sense_short) begin
                  state <= SDFP_FAULT;
               end else if (cycle_start && oc_seen && oc_count >= 8'(OCP_LIMIT)) begin
                  state <= SDFP_FAULT;
               end
            end
            SDFP_FAULT: begin
               state <= SDFP_FAULT; // stays biased until uvlo
            end
            default: begin
               state <= SDFP_OFF;
            end
         endcase
      end
   end
   // soft-start cycle counter
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         soft_count <= 8'h00;
      end else if (state != SDFP_SOFT) begin
         soft_count <= 8'h00;
      end else if (cycle_start && soft_count != 8'hFF) begin
         soft_count <= soft_count + 8'h01;
      end
   end
   // consecutive over-current counting; clean cycle clears
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         oc_count <= 8'h00;
         oc_seen <= 1'b0;
      end else if (state != SDFP_RUN && state != SDFP_SOFT) begin
         oc_count <= 8'h00;
         oc_seen <= 1'b0;
      end else if (cycle_start) begin
         oc_count <= oc_seen ? oc_count + 8'h01 : 8'h00;
         oc_seen <= oc_hit && gate_req;
      end else if (oc_hit && gate_req) begin
         oc_seen <= 1'b1;
      end
   end
   // cut latch ends pulse for rest of cycle; a crossing wins over the cycle start
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cut <= 1'b0;
      end else if (oc_hit && gate_req) begin
         cut <= 1'b1;
      end else if (cycle_start) begin
         cut <= 1'b0;
      end
   end
   // request before the comparator; drive_on itself drops as soon as the sense crosses
   assign gate_req = pulse_req && (!cut || cycle_start) && !uvlo && !sense_short
      && (state == SDFP_SOFT || state == SDFP_RUN);
   // drive gating: off on cut, short, fault or undervoltage
   assign drive_on = gate_req && !oc_hit;
   assign overcurrent_event = oc_hit && (state == SDFP_SOFT || state == SDFP_RUN);
   assign shutdown = state == SDFP_FAULT;
   assign running = state == SDFP_RUN;
   // peak sense capture over each cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         peak_sense_level <= '0;
      end else if (cycle_start) begin
         peak_sense_level <= '0;
      end else if (drive_on && current_sense_input > peak_sense_level) begin
         peak_sense_level <= current_sense_input;
      end
   end
   // drive level chosen from last cycle's peak
   sdfp_base_drive u_drive (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .cycle_start(cycle_start),
      .peak_sense_level(peak_sense_level),
      .base_drive_ma(base_drive_ma)
   );
   sdfp_cable_comp #(.VOUT_MV(VOUT_MV)) u_comp (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .load_estimate(load_estimate),
      .feedback_in(feedback_in),
      .feedback_comp(feedback_comp)
   );
   property p_oc_cuts;
      @(posedge core_clk) disable iff (!rst_b)
         oc_hit && gate_req ##1 !cycle_start |-> !drive_on;
   endproperty
   a_oc_cuts: assert property (p_oc_cuts) else $error("drive not cut after over-current");
   property p_oc_now;
      @(posedge core_clk) disable iff (!rst_b) oc_hit |-> !drive_on;
   endproperty
   a_oc_now: assert property (p_oc_now) else $error("drive on above threshold");
   property p_fresh;
      @(posedge core_clk) disable iff (!rst_b)
         cycle_start && pulse_req && !oc_hit && !uvlo && !sense_short && state == SDFP_RUN |-> drive_on;
   endproperty
   a_fresh: assert property (p_fresh) else $error("no fresh pulse");
   property p_uvlo;
      @(posedge core_clk) disable iff (!rst_b) uvlo |-> !drive_on ##1 state == SDFP_OFF;
   endproperty
   a_uvlo: assert property (p_uvlo) else $error("switching under uvlo");
   property p_short;
      @(posedge core_clk) disable iff (!rst_b) state == SDFP_RUN && sense_short && !uvlo |=> shutdown;
   endproperty
   a_short: assert property (p_short) else $error("short did not shut down");
   property p_fault_quiet;
      @(posedge core_clk) disable iff (!rst_b) shutdown |-> !drive_on;
   endproperty
   a_fault_quiet: assert property (p_fault_quiet) else $error("switching in fault");
   property p_count;
      @(posedge core_clk) disable iff (!rst_b)
         state == SDFP_RUN && cycle_start && oc_seen && oc_count >= 8'(OCP_LIMIT) && !uvlo |=> shutdown;
   endproperty
   a_count: assert property (p_count) else $error("ocp count did not shut down");
   property p_no_run_short;
      @(posedge core_clk) disable iff (!rst_b) state == SDFP_SOFT && sense_short |=> !running;
   endproperty
   a_no_run_short: assert property (p_no_run_short) else $error("started with short");
   // held cut keeps the switch off for the remainder of the cycle
   property p_cut_hold;
      @(posedge core_clk) disable iff (!rst_b) cut && !cycle_start |-> !drive_on;
   endproperty
   a_cut_hold: assert property (p_cut_hold) else $error("drive during cut");
   // a clean cycle forgets earlier over-current cycles
   property p_clean_clears;
      @(posedge core_clk) disable iff (!rst_b) cycle_start && !oc_seen && !uvlo && running |=> oc_count == 8'h00;
   endproperty
   a_clean_clears: assert property (p_clean_clears) else $error("clean cycle kept count");
   // no drive from the off state
   property p_off_quiet;
      @(posedge core_clk) disable iff (!rst_b) state == SDFP_OFF |-> !drive_on;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("switching while off");
   c_oc: cover property (@(posedge core_clk) disable iff (!rst_b) oc_hit && gate_req);
   c_short: cover property (@(posedge core_clk) disable iff (!rst_b) running && sense_short);
   c_fault: cover property (@(posedge core_clk) disable iff (!rst_b) shutdown ##1 uvlo);
   c_run: cover property (@(posedge core_clk) disable iff (!rst_b) running);
endmodule

// ### tb/sdfp_sense_model.sv
// power switch and emitter sense resistor model
`timescale 1ns/1ns
module sdfp_sense_model (
   input wire logic core_clk,
   input wire logic drive_on,
   input wire logic [11:0] slope,
   input wire logic shorted,
   output logic [11:0] current_sense_input = 12'h000,
   output logic sense_short
);
   // current ramps only while base is driven; resistor pulls the pin to ground when off
   always @(posedge core_clk) begin
      if (drive_on === 1'b1 && !shorted) begin
         current_sense_input <= current_sense_input + slope;
      end else begin
         current_sense_input <= 12'h000;
      end
   end
   // a shorted resistor shows no voltage, so only the detector sees it
   assign sense_short = shorted;
endmodule

// ### tb/switch_drive_fault_protection_bench.sv
// self-checking bench for the switch drive fault protection block
`timescale 1ns/1ns
module switch_drive_fault_protection_bench;
   import sdfp_pkg::*;
   localparam int LIM = 2;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic uvlo = 1'b0;
   logic cycle_start = 1'b0;
   logic pulse_req = 1'b0;
   logic shorted = 1'b0;
   logic [11:0] slope = 12'h000;
   logic [11:0] load_estimate = 12'h000;
   logic [15:0] feedback_in = 16'h0000;
   logic [11:0] current_sense_input, peak_sense_level;
   logic sense_short, drive_on, overcurrent_event, shutdown, running;
   logic saw_on, saw_oc, bad;
   logic [4:0] base_drive_ma, lo, hi;
   logic [15:0] feedback_comp;
   int fail_count = 0;
   int n_tests = 0;
   int ticks = 0;
   // short counts keep the run brief
   sdfp_top #(.OCP_LIMIT(LIM), .SOFT_CYCLES(LIM), .VOUT_MV(16'h1388)) uut (.core_clk(core_clk), .rst_b(rst_b),
      .uvlo(uvlo), .cycle_start(cycle_start), .pulse_req(pulse_req), .current_sense_input(current_sense_input),
      .sense_short(sense_short), .load_estimate(load_estimate), .feedback_in(feedback_in), .drive_on(drive_on),
      .overcurrent_event(overcurrent_event), .shutdown(shutdown), .running(running),
      .peak_sense_level(peak_sense_level), .base_drive_ma(base_drive_ma), .feedback_comp(feedback_comp));
   sdfp_sense_model model (.core_clk(core_clk), .drive_on(drive_on), .slope(slope), .shorted(shorted),
      .current_sense_input(current_sense_input), .sense_short(sense_short));
   always #25 core_clk = ~core_clk;
   // hang guard
   always @(posedge core_clk) begin
      ticks++;
      if (ticks == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one switching cycle of 8 clocks; entered just after a falling edge
   task automatic sw_cycle(input logic [11:0] s);
      saw_on = 1'b0;
      saw_oc = 1'b0;
      bad = 1'b0;
      slope = s;
      cycle_start = 1'b1;
      pulse_req = 1'b1;
      for (int i = 0; i < 8; i++) begin
         #1;
         // once tripped, drive must stay off until the next cycle start
         if (drive_on === 1'b1 && (saw_oc || overcurrent_event === 1'b1)) bad = 1'b1;
         saw_on = saw_on | (drive_on === 1'b1);
         saw_oc = saw_oc | (overcurrent_event === 1'b1);
         @(negedge core_clk);
         cycle_start = 1'b0;
         // on-time of five clocks, then the switch rests
         if (i == 4) pulse_req = 1'b0;
      end
   endtask
   task automatic bring_up;
      repeat (LIM + 1) sw_cycle(12'h064);
      chk("running", 16'h0001, {15'h0, running});
   endtask
   task automatic uvlo_pulse;
      @(negedge core_clk);
      uvlo = 1'b1;
      #1 chk("drive under uvlo", 16'h0000, {15'h0, drive_on});
      @(negedge core_clk);
      uvlo = 1'b0;
   endtask
   task automatic t_ocp;
      bring_up();
      repeat (LIM) begin
         sw_cycle(12'h1F4);
         chk("oc seen", 16'h0001, {15'h0, saw_oc});
         chk("cut held", 16'h0000, {15'h0, bad});
      end
      sw_cycle(12'h064);
      chk("fresh pulse", 16'h0001, {15'h0, saw_on & ~saw_oc});
      repeat (LIM) sw_cycle(12'h1F4);
      sw_cycle(12'h064);
      chk("count cleared", 16'h0000, {15'h0, shutdown});
      repeat (LIM + 1) sw_cycle(12'h1F4);
      sw_cycle(12'h064);
      chk("oc shutdown", 16'h0001, {15'h0, shutdown});
      sw_cycle(12'h064);
      chk("no switching", 16'h0000, {15'h0, saw_on});
   endtask
   task automatic t_uvlo;
      uvlo_pulse();
      chk("restart not run", 16'h0000, {15'h0, running});
      bring_up();
      @(negedge core_clk);
      cycle_start = 1'b1;
      pulse_req = 1'b1;
      @(negedge core_clk);
      cycle_start = 1'b0;
      #1 chk("drive mid pulse", 16'h0001, {15'h0, drive_on});
      uvlo_pulse();
      bring_up();
   endtask
   task automatic t_short;
      shorted = 1'b1;
      @(negedge core_clk);
      #1 chk("short shutdown", 16'h0001, {15'h0, shutdown});
      sw_cycle(12'h064);
      chk("short no drive", 16'h0000, {15'h0, saw_on});
      uvlo_pulse();
      repeat (LIM + 2) sw_cycle(12'h064);
      chk("short retry", 16'h0000, {15'h0, running});
      shorted = 1'b0;
      uvlo_pulse();
      bring_up();
   endtask
   task automatic t_base;
      repeat (2) sw_cycle(12'h014);
      lo = base_drive_ma;
      repeat (2) sw_cycle(12'h08C);
      hi = base_drive_ma;
      chk("base min", 16'h0001, {15'h0, lo >= SDFP_IB_MIN_MA});
      chk("base max", 16'h0001, {15'h0, hi <= SDFP_IB_MAX_MA});
      chk("base rises", 16'h0001, {15'h0, hi >= lo});
   endtask
   task automatic t_comp;
      feedback_in = 16'h1388;
      repeat (2) @(negedge core_clk);
      chk("no load comp", 16'h1388, feedback_comp);
      load_estimate = 12'hFFF;
      repeat (2) @(negedge core_clk);
      chk("full load comp", 16'h14B4, feedback_comp);
   endtask
   initial begin
      repeat (4) @(negedge core_clk);
      chk("reset drive", 16'h0000, {15'h0, drive_on});
      chk("reset base", 16'h000A, {11'h0, base_drive_ma});
      rst_b = 1'b1;
      t_ocp();
      t_uvlo();
      t_base();
      t_short();
      t_comp();
      conclude();
   end
endmodule
